// [cies_regs.svh]
// constants for the instruction execution subset
// assumes 10-bit instruction words, one word per machine cycle
// Behaviour
// - index decrement, skip next when result is 15
// - disable clears, enable sets interrupt flag
// - acceptance change lags one machine cycle
// - watchdog stop instruction arms stop function
`ifndef CIES_REGS_SVH
`define CIES_REGS_SVH
// ==========================================
// opcodes
`define CIES_OP_DEC_INDEX 10'h017
`define CIES_OP_IRQ_DIS 10'h004
`define CIES_OP_IRQ_EN 10'h005
`define CIES_OP_WDT_STOP 10'h29c
// ==========================================
// values
`define CIES_INDEX_WRAP 4'hf
`define CIES_INDEX_RST 4'h0
`define CIES_IRQ_EN_RST 1'b0
`define CIES_IRQ_LAG 1
`endif

// [cies_pkg.sv]
// types for the instruction execution subset
// assumes cies_regs.svh holds the numbers
`default_nettype none
package cies_pkg;
  typedef logic [9:0] cies_word_t;
  typedef logic [3:0] cies_nib_t;
  typedef enum logic [3:0] {
    cies_op_none = 4'h0,
    cies_op_dec = 4'h1,
    cies_op_dis = 4'h2,
    cies_op_en = 4'h4,
    cies_op_wdt = 4'h8
  } cies_op_e;
endpackage
`default_nettype wire

// [cies_dec_if.sv]
// decoded instruction strobes between decoder and executor
// assumes a single sys_clk domain
`timescale 1ns/100ps
`default_nettype none
interface cies_dec_if;
  logic dec_index;
  logic irq_dis;
  logic irq_en;
  logic wdt_stop;
  modport dec (output dec_index, output irq_dis, output irq_en, output wdt_stop);
  modport exe (input dec_index, input irq_dis, input irq_en, input wdt_stop);
endinterface
`default_nettype wire

// [cies_decode.sv]
// opcode decoder for the four instructions
// assumes instr is valid whenever instr_valid is high
`timescale 1ns/100ps
`default_nettype none
`include "cies_regs.svh"
module cies_decode
  import cies_pkg::*;
(
  input wire cies_word_t instr,
  input wire logic instr_valid,
  cies_dec_if.dec dec
);
  // ==========================================
  // decode
  assign dec.dec_index = instr_valid && (instr == `CIES_OP_DEC_INDEX);
  assign dec.irq_dis = instr_valid && (instr == `CIES_OP_IRQ_DIS);
  assign dec.irq_en = instr_valid && (instr == `CIES_OP_IRQ_EN);
  assign dec.wdt_stop = instr_valid && (instr == `CIES_OP_WDT_STOP);
endmodule
`default_nettype wire

// [cies_top.sv]
// executes index decrement, interrupt enable/disable and watchdog stop arm
// assumes sys_clk is the machine-cycle clock, instr_valid marks one
// executed instruction per cycle, and every input comes from logic
// on that same clock, so nothing here is synchronised
`timescale 1ns/100ps
`default_nettype none
`include "cies_regs.svh"

module cies_top
  import cies_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // executed instruction slot
  input wire cies_word_t instr,
  input wire logic instr_valid,
  // other writes of the index register
  input wire logic index_load,
  input wire cies_nib_t index_load_val,
  // state, each straight from a flop
  output logic [3:0] index_reg,
  output logic skip_next,
  output logic master_irq_enable_flag,
  output logic irq_accept_enable,
  output logic watchdog_stop_armed,
  output logic op_done
);

  // ==========================================
  // helpers

  // one less, so 0 rolls over to 15 as the index does
  function automatic cies_nib_t index_minus_one(
    input cies_nib_t cur
  );
    index_minus_one = cur - 4'h1;
  endfunction

  // underflow test on a freshly decremented index
  function automatic logic index_wrapped(
    input cies_nib_t val
  );
    index_wrapped = (val == `CIES_INDEX_WRAP);
  endfunction

  // a decrement in the same cycle as a load wins; the load is lost
  function automatic cies_nib_t index_next(
    input cies_nib_t cur,
    input logic dec_s,
    input logic load_s,
    input cies_nib_t load_val
  );
    if (dec_s) begin
      index_next = index_minus_one(cur);
    end else if (load_s) begin
      index_next = load_val;
    end else begin
      index_next = cur;
    end
  endfunction

  // disable ahead of enable if both ever strobe: the safer side
  function automatic logic irq_flag_next(
    input logic cur,
    input logic dis_s,
    input logic en_s
  );
    if (dis_s) begin
      irq_flag_next = 1'b0;
    end else if (en_s) begin
      irq_flag_next = 1'b1;
    end else begin
      irq_flag_next = cur;
    end
  endfunction

  // folds the strobes into one code; distinct opcodes keep it one-hot
  function automatic cies_op_e op_class(
    input logic dec_s,
    input logic dis_s,
    input logic en_s,
    input logic wdt_s
  );
    if (dec_s) begin
      op_class = cies_op_dec;
    end else if (dis_s) begin
      op_class = cies_op_dis;
    end else if (en_s) begin
      op_class = cies_op_en;
    end else if (wdt_s) begin
      op_class = cies_op_wdt;
    end else begin
      op_class = cies_op_none;
    end
  endfunction

  // true for any of the four handled instructions
  function automatic logic op_handled(
    input cies_op_e op
  );
    op_handled = (op != cies_op_none);
  endfunction

  // ==========================================
  // decode

  // the slot after an underflow executes nothing here, even if the
  // core still marks it valid
  wire logic exec_valid;
  assign exec_valid = instr_valid & ~skip_next;

  cies_dec_if dec_bus ();

  cies_decode u_cies_decode (
    .instr(instr),
    .instr_valid(exec_valid),
    .dec(dec_bus)
  );

  wire cies_op_e exec_op;
  assign exec_op = op_class(
    dec_bus.dec_index,
    dec_bus.irq_dis,
    dec_bus.irq_en,
    dec_bus.wdt_stop
  );

  wire logic is_dec;
  wire logic is_dis;
  wire logic is_en;
  wire logic is_wdt;
  wire logic any_op;
  assign is_dec = (exec_op == cies_op_dec);
  assign is_dis = (exec_op == cies_op_dis);
  assign is_en = (exec_op == cies_op_en);
  assign is_wdt = (exec_op == cies_op_wdt);
  assign any_op = op_handled(exec_op);

  // ==========================================
  // index register

  wire cies_nib_t dec_result;
  wire cies_nib_t next_index;
  wire logic next_skip;
  assign dec_result = index_minus_one(index_reg);
  assign next_index = index_next(index_reg, is_dec, index_load, index_load_val);
  assign next_skip = is_dec & index_wrapped(dec_result);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      index_reg <= `CIES_INDEX_RST;
    end else begin
      index_reg <= next_index;
    end
  end

  // one-cycle pulse; the core drops the slot that follows
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      skip_next <= 1'b0;
    end else begin
      skip_next <= next_skip;
    end
  end

  // ==========================================
  // interrupt enable

  wire logic next_flag;
  wire logic next_accept;
  assign next_flag = irq_flag_next(master_irq_enable_flag, is_dis, is_en);
  // acceptance takes the flag one machine cycle late; the core gates
  // interrupts with this one, not with the flag
  assign next_accept = master_irq_enable_flag;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      master_irq_enable_flag <= `CIES_IRQ_EN_RST;
    end else begin
      master_irq_enable_flag <= next_flag;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_accept_enable <= `CIES_IRQ_EN_RST;
    end else begin
      irq_accept_enable <= next_accept;
    end
  end

  // ==========================================
  // watchdog stop

  wire logic next_armed;
  // sticky until core reset; no instruction disarms it
  assign next_armed = watchdog_stop_armed | is_wdt;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_stop_armed <= 1'b0;
    end else begin
      watchdog_stop_armed <= next_armed;
    end
  end

  // ==========================================
  // completion

  wire logic next_done;
  // one pulse per handled instruction; no carry lives here to disturb
  assign next_done = any_op;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_done <= 1'b0;
    end else begin
      op_done <= next_done;
    end
  end
endmodule
`default_nettype wire

// [cies_top_assertions.sv]
// checks on the cies_top ports
// assumes bind below, one clock
`timescale 1ns/100ps
`default_nettype none
`include "cies_regs.svh"
// ====
module cies_chk
  import cies_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire cies_word_t instr,
  input wire logic instr_valid,
  input wire logic [3:0] index_reg,
  input wire logic skip_next,
  input wire logic master_irq_enable_flag,
  input wire logic irq_accept_enable,
  input wire logic watchdog_stop_armed,
  input wire logic op_done
);
  // a slot right after a skip executes nothing
  wire x = instr_valid && !skip_next;
  wire d = x && instr == `CIES_OP_DEC_INDEX, e = x && instr == `CIES_OP_IRQ_EN;
  wire c = x && instr == `CIES_OP_IRQ_DIS, w = x && instr == `CIES_OP_WDT_STOP;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_dec_skip: assert property (d |=> skip_next == (index_reg == 4'hf)) else $error("skip");
  a_dec_value: assert property (d |=> index_reg == 4'($past(index_reg) - 4'h1)) else $error("dec");
  a_en_lag: assert property (e |=> master_irq_enable_flag ##1 irq_accept_enable) else $error("en");
  a_dis_lag: assert property (c |=> !master_irq_enable_flag ##1 !irq_accept_enable) else $error("di");
  a_wdt_arm: assert property (w |=> watchdog_stop_armed && op_done) else $error("wdt");
  a_arm_sticky: assert property (watchdog_stop_armed |=> watchdog_stop_armed) else $error("arm lost");
  a_skip_src: assert property (skip_next |-> $past(d)) else $error("skip source");
  a_accept_lag: assert property (irq_accept_enable == $past(master_irq_enable_flag)) else $error("lag");
  a_done_pulse: assert property (op_done == $past(d || e || c || w)) else $error("done");
endmodule
bind cies_top cies_chk u_cies_chk (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .instr(instr),
  .instr_valid(instr_valid),
  .index_reg(index_reg),
  .skip_next(skip_next),
  .master_irq_enable_flag(master_irq_enable_flag),
  .irq_accept_enable(irq_accept_enable),
  .watchdog_stop_armed(watchdog_stop_armed),
  .op_done(op_done)
);
`default_nettype wire

// [ctrl_instr_exec_subset_tb.sv]
// random bench for cies_top
// assumes the checker binds itself
`timescale 1ns/100ps
`default_nettype none
`include "cies_regs.svh"
// ====
module ctrl_instr_exec_subset_tb import cies_pkg::*; ;
  logic sys_clk = 0, rst_n = 0, instr_valid = 0, index_load = 0, skip_next, flag, acc, armed, op_done;
  logic s, p, f = 0, a = 0, d, q = 0, v;
  cies_word_t instr = 10'h000;
  cies_nib_t index_load_val = 4'h0, index_reg, ei = 4'h0;
  int error_cnt = 0, n_tests = 0, k;
  cies_word_t ops [5] = '{`CIES_OP_DEC_INDEX, `CIES_OP_IRQ_DIS, `CIES_OP_IRQ_EN, `CIES_OP_WDT_STOP, 10'h3ff};
  wire [8:0] seen = {index_reg, skip_next, flag, acc, armed, op_done};
  always #12.5 sys_clk = ~sys_clk;
  cies_top u_cies_top (.sys_clk, .rst_n, .instr, .instr_valid, .index_load, .index_load_val, .index_reg,
    .skip_next, .master_irq_enable_flag(flag), .irq_accept_enable(acc), .watchdog_stop_armed(armed), .op_done);
  // decrement beats a load
  function automatic cies_nib_t nxt(input logic dc, ld, input cies_nib_t cur, val);
    return dc ? cur - 4'h1 : ld ? val : cur;
  endfunction
  task chk(input logic [8:0] got, exp);
    n_tests++;
    if (got !== exp) error_cnt++;
    if (got !== exp) $display("wrong value at %0t: %h, expected %h", $time, got, exp);
  endtask
  task end_sim;
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #50000 error_cnt++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h8b59a6f9));
    repeat (20) @(posedge sys_clk);
    #2 chk(seen, 9'h000);
    rst_n = 1;
    for (int i = 0; i < 400; i++) begin
      // a second reset in mid-run must clear the sticky arm
      if (i == 200) begin
        rst_n = 0;
        instr_valid = 0;
        index_load = 0;
        {ei, f, a, q} = 7'h00;
        @(posedge sys_clk);
        #2 chk(seen, 9'h000);
        rst_n = 1;
      end
      // eighteen slots from 0 wrap twice; the slot after a wrap is skipped
      k = i < 18 ? 0 : $urandom_range(4);
      instr = ops[k];
      instr_valid = i < 18 || $urandom_range(3) > 0;
      index_load = $urandom_range(3) == 0;
      index_load_val = 4'($urandom);
      v = instr_valid && !q;
      d = v && k == 0;
      s = d && ei == 4'h0;
      p = f;
      ei = nxt(d, index_load, ei, index_load_val);
      if (v && k inside {1, 2}) f = k == 2;
      a |= v && k == 3;
      @(posedge sys_clk);
      #2 chk(seen, {ei, s, f, p, a, v && k < 4});
      q = s;
    end
    end_sim();
  end
endmodule
`default_nettype wire
